// ### exec_pkg.sv
// Purpose: constants and carriers for the jump/loop/aux/ldst execute unit
// Assumes: 32-bit core, one clock, APB register access
// Notes:   decoded instruction arrives as a packed struct from decode
//
// Overview of operation
// - no-delay mode skips slot only when taken
// - long immediate jumps get no delay slot
// - flagged irq-link jump restores status word
// - taken jump-link writes link, loads pc
// - any target address, forced 16-bit aligned
// - zero-overhead loop compare and decrement
// - loop setup: s12 always sets bounds; other non-reg formats false branches, true sets bounds
// - loop setup in reg formats raises error
// - s12 loop end is pc plus doubled immediate
// - u6 conditional loop setup, false adds offset
// - loop bounds written by aux stores
// - aux access single cycle, no scoreboard
// - aux access stalls only like alu ops
// - aux access 32-bit, always unconditional
// - aux load reads, aux store writes selected
// - pre-update writes back before, post after
// - scaled mode never writes back address
// - zero offset adds nothing to base
// - size from opcode: byte, half, word
// - zero extend by default, sign with suffix
// - taken non-limm jump applies one cycle later
// - load destination pending until data arrives
package exec_pkg;

    // ========================================
    // opcode classes
    typedef enum logic [3:0] {
        OP_NONE  = 4'h0,
        OP_JUMP  = 4'h1,
        OP_JLINK = 4'h2,
        OP_LOOP  = 4'h3,
        OP_AUXLD = 4'h4,
        OP_AUXST = 4'h5,
        OP_LOAD  = 4'h6,
        OP_STORE = 4'h7
    } op_t;

    // operand formats
    typedef enum logic [2:0] {
        FMT_RR   = 3'h0,
        FMT_U6   = 3'h1,
        FMT_S12  = 3'h2,
        FMT_CR   = 3'h3,
        FMT_CU6  = 3'h4,
        FMT_LIMM = 3'h5
    } fmt_t;

    // access sizes
    typedef enum logic [1:0] {
        SZ_WORD = 2'h0,
        SZ_BYTE = 2'h1,
        SZ_HALF = 2'h2
    } size_t;

    // write-back modes
    typedef enum logic [1:0] {
        WB_NONE = 2'h0,
        WB_PRE  = 2'h1,
        WB_POST = 2'h2,
        WB_SCAL = 2'h3
    } wb_t;

    // ========================================
    // aux register numbers (aux space select)
    localparam logic [31:0] AUX_LOOP_START = 32'h0000_0002;
    localparam logic [31:0] AUX_LOOP_END   = 32'h0000_0003;
    localparam logic [31:0] AUX_STATUS     = 32'h0000_000A;
    localparam logic [31:0] AUX_STAT_L1    = 32'h0000_000B;
    localparam logic [31:0] AUX_STAT_L2    = 32'h0000_000C;

    // core register numbers
    localparam logic [5:0] REG_IRQ_LINK1 = 6'h1D;
    localparam logic [5:0] REG_IRQ_LINK2 = 6'h1E;

    // ========================================
    // apb map (byte offsets)
    localparam logic [11:0] APB_LOOP_COUNT = 12'h000;
    localparam logic [11:0] APB_CTRL       = 12'h004;
    localparam logic [11:0] APB_STATE      = 12'h008;
    localparam logic [11:0] APB_PC         = 12'h00C;
    localparam logic [11:0] APB_LINK       = 12'h010;

    // field positions
    localparam int CTRL_HALT_BIT = 0;
    localparam int ST_ERR_BIT    = 0;
    localparam int ST_PEND_BIT   = 1;
    localparam int ST_SLOT_BIT   = 2;

    // reset values and shared constants
    localparam logic [31:0] RST_PC     = 32'h0000_0000;
    localparam logic [31:0] RST_STATUS = 32'h0000_0000;
    localparam logic [31:0] ZERO32     = 32'h0000_0000;
    localparam logic [31:0] ONE32      = 32'h0000_0001;
    localparam logic [31:0] ALIGN_MASK = 32'hFFFF_FFFE;

    // decoded instruction from decode
    typedef struct packed {
        logic        valid;
        op_t         op;
        fmt_t        fmt;
        logic        cond;
        logic        delay;
        logic        flag;
        logic [5:0]  src_reg;
        logic [5:0]  dst_reg;
        logic [31:0] pc;
        logic [31:0] following_instr_addr;
        logic [31:0] src_b;
        logic [31:0] src_c;
        logic [31:0] imm;
        size_t       size;
        logic        sext;
        wb_t         wb;
        logic        reads_pending;
    } instr_t;

    // memory request to memory controller
    typedef struct packed {
        logic        valid;
        logic        write;
        size_t       size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } mem_req_t;

    // register write-back port
    typedef struct packed {
        logic        valid;
        logic [5:0]  reg_num;
        logic [31:0] data;
    } reg_wr_t;

endpackage

// ### jump_loop_auxreg_ldst_exec.sv
// Purpose: execute stage for jumps, loops, aux access and load/store
// Assumes: decode supplies resolved operands and condition result
// Notes:   memory data returns by mem_rvalid, one load outstanding
//
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/1ps
module jump_loop_auxreg_ldst_exec (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire exec_pkg::instr_t  instr,
    output logic                   instr_ready,
    output logic [31:0]            fetch_pc,
    output logic                   kill_next,
    output logic                   instr_err,
    output exec_pkg::mem_req_t     mem_req,
    input  wire logic              mem_ready,
    input  wire logic              mem_rvalid,
    input  wire logic [31:0]       mem_rdata,
    output exec_pkg::reg_wr_t      reg_wr,
    output logic [31:0]            status_word,
    input  wire logic [31:0]       irq_link_reg_one,
    input  wire logic [31:0]       irq_link_reg_two,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr
);

    // ========================================
    // state
    typedef struct packed {
        logic [31:0]       pc;
        logic [31:0]       tgt;
        logic              tgt_pend;
        logic              kill;
        logic [31:0]       link;
        logic [31:0]       loop_start_reg;
        logic [31:0]       loop_end_reg;
        logic [31:0]       loop_count_reg;
        logic [31:0]       status;
        logic [31:0]       stat_l1;
        logic [31:0]       stat_l2;
        logic              err;
        logic              halt;
        logic              ld_pend;
        logic [5:0]        ld_reg;
        exec_pkg::size_t   ld_size;
        logic              ld_sext;
        exec_pkg::mem_req_t req;
        exec_pkg::reg_wr_t wr;
        logic              post_wb;
        logic [5:0]        post_reg;
        logic [31:0]       post_addr;
        logic [31:0]       prdata;
    } state_t;

    state_t cur_ff;   // registered state
    state_t nxt_st;   // next state

    // ========================================
    // helpers
    // extend a loaded value by size
    function automatic logic [31:0] extend(input logic [31:0] d,
                                           input exec_pkg::size_t s,
                                           input logic sx);
        logic [31:0] r;
        r = d;
        unique case (s)
            exec_pkg::SZ_BYTE: r = sx ? {{24{d[7]}}, d[7:0]} : {24'h000000, d[7:0]};
            exec_pkg::SZ_HALF: r = sx ? {{16{d[15]}}, d[15:0]} : {16'h0000, d[15:0]};
            exec_pkg::SZ_WORD: r = d;
        endcase
        return r;
    endfunction

    // align any jump target to a halfword
    function automatic logic [31:0] align(input logic [31:0] a);
        return a & exec_pkg::ALIGN_MASK;
    endfunction

    // ========================================
    // combinational next state
    logic        stall;      // hold decode
    logic        apb_acc;    // apb access phase
    logic [31:0] offs;       // effective offset
    logic [31:0] addr;       // computed address
    logic        mem_op;     // load or store
    always_comb begin
        nxt_st   = cur_ff;
        apb_acc  = psel && penable;
        mem_op   = instr.valid && (instr.op == exec_pkg::OP_LOAD ||
                                   instr.op == exec_pkg::OP_STORE);
        // alu-like hazard for any op reading a pending register; memory ops also wait for controller
        stall    = cur_ff.halt ||
                   (instr.valid && instr.reads_pending && cur_ff.ld_pend) ||
                   (mem_op && (cur_ff.req.valid || cur_ff.ld_pend));
        // scaled offset shift by log2 size
        offs = instr.src_c;
        if (instr.wb == exec_pkg::WB_SCAL) begin
            unique case (instr.size)
                exec_pkg::SZ_HALF: offs = instr.src_c << 1;
                exec_pkg::SZ_WORD: offs = instr.src_c << 2;
                exec_pkg::SZ_BYTE: offs = instr.src_c;
            endcase
        end
        addr = instr.src_b + offs;
        nxt_st.wr.valid = 1'b0;
        nxt_st.kill     = 1'b0;
        nxt_st.err      = 1'b0;

        // delayed jump applies one cycle after the jump
        if (cur_ff.tgt_pend) begin
            nxt_st.pc       = cur_ff.tgt;
            nxt_st.tgt_pend = 1'b0;
        end else if (!stall && instr.valid) begin
            nxt_st.pc = instr.following_instr_addr;
        end

        // zero-overhead loop: compare and decrement in the same cycle
        if (!stall && instr.valid && !cur_ff.tgt_pend &&
            instr.following_instr_addr == cur_ff.loop_end_reg && cur_ff.loop_count_reg != exec_pkg::ZERO32 &&
            cur_ff.loop_count_reg != exec_pkg::ONE32) begin
            nxt_st.pc             = cur_ff.loop_start_reg;
            nxt_st.loop_count_reg = cur_ff.loop_count_reg - exec_pkg::ONE32;
        end else if (!stall && instr.valid && instr.following_instr_addr == cur_ff.loop_end_reg &&
                     cur_ff.loop_count_reg != exec_pkg::ZERO32) begin
            nxt_st.loop_count_reg = cur_ff.loop_count_reg - exec_pkg::ONE32;
        end

        // memory request retire
        if (cur_ff.req.valid && mem_ready) begin
            nxt_st.req.valid = 1'b0;
            if (cur_ff.post_wb) begin
                nxt_st.wr       = '{valid: 1'b1, reg_num: cur_ff.post_reg,
                                    data: cur_ff.post_addr};
                nxt_st.post_wb  = 1'b0;
            end
        end
        // load data return clears pending tag
        if (cur_ff.ld_pend && mem_rvalid && !cur_ff.req.valid) begin
            nxt_st.ld_pend = 1'b0;
            nxt_st.wr = '{valid: 1'b1, reg_num: cur_ff.ld_reg,
                          data: extend(mem_rdata, cur_ff.ld_size, cur_ff.ld_sext)};
        end

        if (!stall && instr.valid) begin
            unique case (instr.op)
                exec_pkg::OP_JUMP, exec_pkg::OP_JLINK: begin
                    if (instr.cond) begin
                        if (instr.op == exec_pkg::OP_JLINK) begin
                            nxt_st.link = instr.following_instr_addr;
                        end
                        if (instr.flag && instr.src_reg == exec_pkg::REG_IRQ_LINK1) begin
                            nxt_st.tgt    = align(irq_link_reg_one);
                            nxt_st.status = cur_ff.stat_l1;
                        end else if (instr.flag && instr.src_reg == exec_pkg::REG_IRQ_LINK2) begin
                            nxt_st.tgt    = align(irq_link_reg_two);
                            nxt_st.status = cur_ff.stat_l2;
                        end else begin
                            nxt_st.tgt = align(instr.src_c);
                        end
                        if (instr.fmt == exec_pkg::FMT_LIMM) begin
                            // limm word occupies the next slot: jump directly
                            nxt_st.pc = nxt_st.tgt;
                        end else begin
                            nxt_st.tgt_pend = 1'b1;
                            nxt_st.kill     = !instr.delay;
                        end
                    end
                end
                exec_pkg::OP_LOOP: begin
                    if (instr.fmt == exec_pkg::FMT_RR || instr.fmt == exec_pkg::FMT_CR) begin
                        nxt_st.err = 1'b1;
                    end else if (instr.fmt == exec_pkg::FMT_S12) begin
                        nxt_st.loop_end_reg   = align(instr.pc + (instr.imm << 1));
                        nxt_st.loop_start_reg = instr.following_instr_addr;
                    end else if (instr.cond) begin
                        nxt_st.loop_end_reg   = align(instr.pc + (instr.imm << 1));
                        nxt_st.loop_start_reg = instr.following_instr_addr;
                    end else begin
                        nxt_st.pc = align(instr.pc + (instr.imm << 1));
                    end
                end
                exec_pkg::OP_AUXLD: begin
                    // single cycle, 32-bit, ignores condition
                    nxt_st.wr.valid   = 1'b1;
                    nxt_st.wr.reg_num = instr.dst_reg;
                    unique case (instr.src_c)
                        exec_pkg::AUX_LOOP_START: nxt_st.wr.data = cur_ff.loop_start_reg;
                        exec_pkg::AUX_LOOP_END:   nxt_st.wr.data = cur_ff.loop_end_reg;
                        exec_pkg::AUX_STATUS:     nxt_st.wr.data = cur_ff.status;
                        exec_pkg::AUX_STAT_L1:    nxt_st.wr.data = cur_ff.stat_l1;
                        exec_pkg::AUX_STAT_L2:    nxt_st.wr.data = cur_ff.stat_l2;
                        default:                  nxt_st.wr.data = exec_pkg::ZERO32;
                    endcase
                end
                exec_pkg::OP_AUXST: begin
                    unique case (instr.src_c)
                        exec_pkg::AUX_LOOP_START: nxt_st.loop_start_reg = instr.src_b;
                        exec_pkg::AUX_LOOP_END:   nxt_st.loop_end_reg = instr.src_b;
                        exec_pkg::AUX_STATUS:     nxt_st.status = instr.src_b;
                        exec_pkg::AUX_STAT_L1:    nxt_st.stat_l1 = instr.src_b;
                        exec_pkg::AUX_STAT_L2:    nxt_st.stat_l2 = instr.src_b;
                        default:                  nxt_st.status = cur_ff.status;
                    endcase
                end
                exec_pkg::OP_LOAD, exec_pkg::OP_STORE: begin
                    nxt_st.req.valid = 1'b1;
                    nxt_st.req.write = (instr.op == exec_pkg::OP_STORE);
                    nxt_st.req.size  = instr.size;
                    nxt_st.req.wdata = instr.imm;
                    // post-update uses base; pre and scaled use computed address
                    nxt_st.req.addr  = (instr.wb == exec_pkg::WB_POST) ? instr.src_b : addr;
                    if (instr.wb == exec_pkg::WB_PRE) begin
                        nxt_st.wr = '{valid: 1'b1, reg_num: instr.src_reg, data: addr};
                    end
                    nxt_st.post_wb   = (instr.wb == exec_pkg::WB_POST);
                    nxt_st.post_reg  = instr.src_reg;
                    nxt_st.post_addr = addr;
                    if (instr.op == exec_pkg::OP_LOAD) begin
                        nxt_st.ld_pend = 1'b1;
                        nxt_st.ld_reg  = instr.dst_reg;
                        nxt_st.ld_size = instr.size;
                        nxt_st.ld_sext = instr.sext;
                    end
                end
                default: begin
                    nxt_st.err = 1'b0;
                end
            endcase
        end

        // apb: loop count as ordinary register, control, state
        if (apb_acc && pwrite) begin
            if (paddr == exec_pkg::APB_LOOP_COUNT) nxt_st.loop_count_reg = pwdata;
            if (paddr == exec_pkg::APB_CTRL)       nxt_st.halt = pwdata[exec_pkg::CTRL_HALT_BIT];
        end
        nxt_st.prdata = exec_pkg::ZERO32;
        if (psel && !penable && !pwrite) begin
            unique case (paddr)
                exec_pkg::APB_LOOP_COUNT: nxt_st.prdata = cur_ff.loop_count_reg;
                exec_pkg::APB_CTRL:       nxt_st.prdata = {31'h0, cur_ff.halt};
                exec_pkg::APB_STATE:      nxt_st.prdata = {29'h0, cur_ff.tgt_pend,
                                                           cur_ff.ld_pend, cur_ff.err};
                exec_pkg::APB_PC:         nxt_st.prdata = cur_ff.pc;
                exec_pkg::APB_LINK:       nxt_st.prdata = cur_ff.link;
                default:                  nxt_st.prdata = exec_pkg::ZERO32;
            endcase
        end
    end

    // ========================================
    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_ff        <= '0;
            cur_ff.pc     <= exec_pkg::RST_PC;
            cur_ff.status <= exec_pkg::RST_STATUS;
        end else begin
            cur_ff <= nxt_st;
        end
    end

    // ========================================
    // outputs
    logic unmapped;   // address outside map
    assign unmapped    = paddr > exec_pkg::APB_LINK || paddr[1:0] != 2'h0;
    assign instr_ready = !stall;
    assign fetch_pc    = cur_ff.pc;
    assign kill_next   = cur_ff.kill;
    assign instr_err   = cur_ff.err;
    assign mem_req     = cur_ff.req;
    assign reg_wr      = cur_ff.wr;
    assign status_word = cur_ff.status;
    assign prdata      = cur_ff.prdata;
    assign pready      = 1'b1;
    assign pslverr     = psel && penable && unmapped;

    // ========================================
    // checks
    sequence jump_taken_s;
        instr.valid && !stall && instr.op == exec_pkg::OP_JUMP && instr.cond &&
        instr.fmt != exec_pkg::FMT_LIMM && !instr.flag;
    endsequence
    jump_late_a: assert property (@(posedge pclk) disable iff (!presetn)
        jump_taken_s ##1 1'b1 |=> fetch_pc == $past(align(instr.src_c), 2))
        else $error("delayed jump target wrong");
    nd_kill_a: assert property (@(posedge pclk) disable iff (!presetn)
        jump_taken_s |=> kill_next == !$past(instr.delay))
        else $error("delay slot kill wrong");
    limm_now_a: assert property (@(posedge pclk) disable iff (!presetn)
        instr.valid && !stall && instr.op == exec_pkg::OP_JUMP && instr.cond &&
        instr.fmt == exec_pkg::FMT_LIMM && !instr.flag && !cur_ff.tgt_pend
        |=> !kill_next && fetch_pc == $past(align(instr.src_c)))
        else $error("limm jump not direct");
    align_a: assert property (@(posedge pclk) disable iff (!presetn)
        cur_ff.tgt_pend |-> !cur_ff.tgt[0])
        else $error("jump target misaligned");
    link_a: assert property (@(posedge pclk) disable iff (!presetn)
        instr.valid && !stall && instr.op == exec_pkg::OP_JLINK && instr.cond
        |=> cur_ff.link == $past(instr.following_instr_addr))
        else $error("link not written");
    loop_err_a: assert property (@(posedge pclk) disable iff (!presetn)
        instr.valid && !stall && instr.op == exec_pkg::OP_LOOP &&
        (instr.fmt == exec_pkg::FMT_RR || instr.fmt == exec_pkg::FMT_CR) |=> instr_err)
        else $error("loop format error missing");
    aux_one_a: assert property (@(posedge pclk) disable iff (!presetn)
        instr.valid && !stall && instr.op == exec_pkg::OP_AUXLD
        |=> reg_wr.valid && reg_wr.reg_num == $past(instr.dst_reg))
        else $error("aux load not single cycle");
    pend_a: assert property (@(posedge pclk) disable iff (!presetn)
        cur_ff.ld_pend && instr.valid && instr.reads_pending |-> !instr_ready)
        else $error("pending register read");
    scaled_a: assert property (@(posedge pclk) disable iff (!presetn)
        instr.valid && !stall && mem_op && instr.wb == exec_pkg::WB_SCAL
        |=> !cur_ff.post_wb ##1 !(reg_wr.valid && reg_wr.reg_num == $past(instr.src_reg, 2)
            && !cur_ff.ld_pend))
        else $error("scaled mode wrote back");

endmodule

// ### mem_model.sv
// Purpose: memory controller stand-in for the execute unit's data port
// Assumes: one request at a time, lag sets the wait before ready
// Notes:   released read bus toggles so stale data never looks valid
`timescale 1ns/1ps
module mem_model (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire exec_pkg::mem_req_t mem_req,
    input  wire logic [1:0]         lag,
    output logic                    mem_ready,
    output logic                    mem_rvalid,
    output logic [31:0]             mem_rdata
);
    // ==========================================
    // request acceptance and load return
    logic [1:0] cnt_ff;  // cycles waited on current request
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff     <= 2'h0;
            mem_ready  <= 1'b0;
            mem_rvalid <= 1'b0;
            mem_rdata  <= 32'h0000_0000;
        end else begin
            mem_ready  <= 1'b0;
            mem_rvalid <= 1'b0;
            mem_rdata  <= ~mem_rdata;  // idle line never holds a value
            if (mem_ready && mem_req.valid) begin
                // retired: loads answer one cycle later, at the earliest
                mem_rvalid <= !mem_req.write;
                mem_rdata  <= 32'h1234_C680;
            end else if (mem_req.valid) begin
                // slow answer when lag is nonzero
                mem_ready <= (cnt_ff == lag);
                cnt_ff    <= (cnt_ff == lag) ? 2'h0 : cnt_ff + 2'h1;
            end
        end
    end
endmodule

// ### tb.sv
// Purpose: directed bench for jump, loop, aux and load/store execution
// Assumes: APB zero wait, effects one cycle after an instruction is taken
// Notes:   memory data fixed at 1234C680 so extension is visible
`timescale 1ns/1ps
module tb;
    logic               pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic               pwrite = 1'b0, pready, pslverr, instr_ready, kill_next, instr_err;
    logic               mem_ready, mem_rvalid, e;
    logic [11:0]        paddr = 12'h000;
    logic [31:0]        pwdata = 32'h0, prdata, fetch_pc, status_word, mem_rdata, q;
    logic [31:0]        link1 = 32'h0000_2000, link2 = 32'h0000_3000;
    logic [1:0]         lag = 2'h0;
    exec_pkg::instr_t   instr = '0, ins;
    exec_pkg::mem_req_t mem_req;
    exec_pkg::reg_wr_t  reg_wr;
    int                 fail_count = 0, total_checks = 0, cyc = 0;
    jump_loop_auxreg_ldst_exec dut (.pclk(pclk), .presetn(presetn), .instr(instr),
        .instr_ready(instr_ready), .fetch_pc(fetch_pc), .kill_next(kill_next),
        .instr_err(instr_err), .mem_req(mem_req), .mem_ready(mem_ready),
        .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata), .reg_wr(reg_wr),
        .status_word(status_word), .irq_link_reg_one(link1), .irq_link_reg_two(link2),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    mem_model mem (.pclk(pclk), .presetn(presetn), .mem_req(mem_req), .lag(lag),
        .mem_ready(mem_ready), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));
    // ==========================================
    // clock, hang guard
    always #10 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fail_count++;
            test_done();
        end
    end
    // ==========================================
    // shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // setup then access; data and error taken at the edge that samples pready high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    // returns on the edge that takes the instruction
    task automatic issue(input exec_pkg::instr_t i);
        @(posedge pclk);
        instr <= i;
        do @(posedge pclk); while (instr_ready !== 1'b1);
        instr.valid <= 1'b0;
    endtask
    task automatic wait_wr();
        int n;
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (reg_wr.valid !== 1'b1 && n < 20);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // jump helper: kill pulse in c1, new pc in c2
    task automatic jump(input exec_pkg::op_t o, input exec_pkg::fmt_t f, input logic d,
                        input logic [31:0] t, input logic [31:0] exp);
        ins = '0; ins.valid = 1'b1; ins.op = o; ins.cond = 1'b1;
        ins.delay = d; ins.fmt = f; ins.src_c = t; ins.following_instr_addr = 32'h0000_0020;
        issue(ins);
        @(negedge pclk);
        check({31'h0, kill_next}, {31'h0, !d && f != exec_pkg::FMT_LIMM});
        if (f == exec_pkg::FMT_LIMM) check(fetch_pc, exp);
        @(negedge pclk);
        check(fetch_pc, exp);
    endtask
    // ==========================================
    // main sequence
    logic [1:0]  szs [5] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h0};
    logic [31:0] exps[5] = '{32'h80, 32'hFFFF_FF80, 32'hC680, 32'hFFFF_C680, 32'h1234_C680};
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        check(fetch_pc, exec_pkg::RST_PC);
        apb(1'b1, exec_pkg::APB_LOOP_COUNT, 32'h5);
        apb(1'b0, exec_pkg::APB_LOOP_COUNT, 32'h0);
        check(q, 32'h5);
        apb(1'b0, 12'h0FC, 32'h0);
        check({31'h0, e}, 32'h1);
        jump(exec_pkg::OP_JUMP, exec_pkg::FMT_RR, 1'b0, 32'h0000_1235, 32'h0000_1234);
        jump(exec_pkg::OP_JLINK, exec_pkg::FMT_RR, 1'b1, 32'h8000_0100, 32'h8000_0100);
        apb(1'b0, exec_pkg::APB_LINK, 32'h0);
        check(q, 32'h0000_0020);
        jump(exec_pkg::OP_JUMP, exec_pkg::FMT_LIMM, 1'b0, 32'h0000_0501, 32'h0000_0500);
        // saved status then irq return
        ins = '0; ins.valid = 1'b1; ins.op = exec_pkg::OP_AUXST;
        ins.src_b = 32'h55; ins.src_c = exec_pkg::AUX_STAT_L1;
        issue(ins);
        ins = '0; ins.valid = 1'b1; ins.op = exec_pkg::OP_JUMP; ins.cond = 1'b1;
        ins.flag = 1'b1; ins.src_reg = exec_pkg::REG_IRQ_LINK1; ins.src_c = link1;
        issue(ins);
        repeat (2) @(negedge pclk);
        check(fetch_pc, link1);
        check(status_word, 32'h55);
        // loop setup formats
        ins = '0; ins.valid = 1'b1; ins.op = exec_pkg::OP_LOOP; ins.fmt = exec_pkg::FMT_CR;
        issue(ins);
        @(negedge pclk);
        check({31'h0, instr_err}, 32'h1);
        ins.fmt = exec_pkg::FMT_S12; ins.pc = 32'h40; ins.following_instr_addr = 32'h44;
        ins.imm = 32'h10; ins.cond = 1'b1;
        issue(ins);
        ins = '0; ins.valid = 1'b1; ins.op = exec_pkg::OP_AUXLD; ins.dst_reg = 6'h3;
        ins.src_c = exec_pkg::AUX_LOOP_END;
        issue(ins);
        wait_wr();
        check(reg_wr.data, 32'h60);
        ins.src_c = exec_pkg::AUX_LOOP_START;
        issue(ins);
        wait_wr();
        check(reg_wr.data, 32'h44);
        ins = '0; ins.valid = 1'b1; ins.op = exec_pkg::OP_LOOP; ins.fmt = exec_pkg::FMT_CU6;
        ins.pc = 32'h80; ins.imm = 32'h8;
        issue(ins);
        repeat (2) @(negedge pclk);
        check(fetch_pc, 32'h90);
        // loads: no scaled byte, no sign suffix on words
        for (int k = 0; k < 6; k++) begin
            lag <= k[1:0];
            ins = '0; ins.valid = 1'b1; ins.op = exec_pkg::OP_LOAD; ins.dst_reg = 6'h7;
            ins.src_b = 32'h100; ins.size = exec_pkg::size_t'(k < 5 ? szs[k] : 2'h2);
            ins.sext = (k == 1 || k == 3);
            ins.wb = (k == 5) ? exec_pkg::WB_SCAL : exec_pkg::WB_NONE;
            ins.src_c = (k == 5) ? 32'h4 : 32'h0;
            issue(ins);
            wait_wr();
            check(mem_req.addr, (k == 5) ? 32'h108 : 32'h100);
            check({30'h0, mem_req.size}, {30'h0, ins.size});
            check(reg_wr.data, (k < 5) ? exps[k] : 32'hC680);
            check({26'h0, reg_wr.reg_num}, 32'h7);
        end
        // dependent aux read must wait out the load, then a post-update store
        issue(ins);
        ins.op = exec_pkg::OP_AUXLD; ins.reads_pending = 1'b1;
        issue(ins);
        apb(1'b0, exec_pkg::APB_STATE, 32'h0);
        check(q, 32'h0);
        ins.op = exec_pkg::OP_STORE; ins.wb = exec_pkg::WB_POST; ins.src_reg = 6'h2;
        issue(ins);
        wait_wr();
        check(reg_wr.data, 32'h104);
        check(mem_req.addr, 32'h100);
        test_done();
    end
endmodule
